// *** rtl/ppcl_pkg.sv ***
// Behaviour
// R1 - Skip bit one hides pin from crossbar
// R2 - Software skips analog and special-function pins
// R3 - Latch bit zero drives low, one high
// R4 - Open-drain pin with latch one floats
// R5 - Latch read: analog zero, else pin level
// R6 - Analog pin ignores its output-mode bit
// R7 - Output-mode zero selects open-drain driver
// R8 - Push-pull on one; analog disables digital path
package ppcl_pkg;
    localparam logic [7:0] PPCL_ADDR_DRIVER_TYPE = 8'hAE;
    localparam logic [7:0] PPCL_ADDR_LATCH = 8'hC7;
    localparam logic [7:0] PPCL_ADDR_SKIP = 8'hDF;
    localparam logic [7:0] PPCL_ADDR_ANALOG_SEL = 8'hF5;
    localparam logic [7:0] PPCL_RST_DRIVER_TYPE = 8'h00;
    localparam logic [7:0] PPCL_RST_LATCH = 8'hFF;
    localparam logic [7:0] PPCL_RST_SKIP = 8'h00;
    localparam logic [7:0] PPCL_RST_ANALOG_SEL = 8'hFF;
    localparam logic [7:0] PPCL_RST_PIN_SYNC = 8'hFF;
    localparam logic [7:0] PPCL_RST_RDATA = 8'h00;
    localparam logic [7:0] PPCL_RST_PIN_OE = 8'h00;
    localparam logic [3:0] PPCL_RST_XBAR_SKIP = 4'h0;
    localparam int PPCL_SKIP_LSB = 0;
    localparam int PPCL_SKIP_WIDTH = 4;
endpackage : ppcl_pkg

// *** rtl/ppcl_port_pin_config_latch.sv ***
`timescale 1ns/1ps
module ppcl_port_pin_config_latch
    import ppcl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic [7:0] port4_pin_i,
    output logic [7:0] port4_pin_o,
    output logic [7:0] port4_pin_oe_o,
    output logic [7:0] port4_pullup_en_o,
    output logic [7:0] port4_digital_rx_en_o,
    output logic [3:0] port3_crossbar_skip_o
);

    function automatic logic ppcl_hit(input logic [7:0] addr, input logic [7:0] target);
        ppcl_hit = (addr == target);
    endfunction : ppcl_hit

    logic [7:0] driver_type_reg, driver_type_next;
    logic [7:0] latch_reg, latch_next;
    logic [7:0] skip_reg, skip_next;
    logic [7:0] analog_sel_reg, analog_sel_next;
    logic [7:0] sync1_reg, sync1_next;
    logic [7:0] sync2_reg, sync2_next;
    logic [7:0] sync3_reg, sync3_next;
    logic [7:0] level_reg, level_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] pin_out_reg, pin_out_next;
    logic [7:0] pin_oe_reg, pin_oe_next;
    logic [7:0] pullup_reg, pullup_next;
    logic [7:0] rx_en_reg, rx_en_next;
    logic [3:0] xbar_skip_reg, xbar_skip_next;

    always_comb
    begin
        driver_type_next = driver_type_reg;
        latch_next = latch_reg;
        skip_next = skip_reg;
        analog_sel_next = analog_sel_reg;
        if (sfr_wr_i)
        begin
            if (ppcl_hit(sfr_addr_i, PPCL_ADDR_DRIVER_TYPE))
            begin
                driver_type_next = sfr_wdata_i;
            end
            if (ppcl_hit(sfr_addr_i, PPCL_ADDR_LATCH))
            begin
                latch_next = sfr_wdata_i;
            end
            if (ppcl_hit(sfr_addr_i, PPCL_ADDR_SKIP))
            begin
                skip_next = sfr_wdata_i;
            end
            if (ppcl_hit(sfr_addr_i, PPCL_ADDR_ANALOG_SEL))
            begin
                analog_sel_next = sfr_wdata_i;
            end
        end
    end

    // Pin synchroniser; level follows once stages two and three agree
    always_comb
    begin
        sync1_next = port4_pin_i;
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
        level_next = level_reg;
        for (int i = 0; i < 8; i++)
        begin
            if (sync2_reg[i] == sync3_reg[i])
            begin
                level_next[i] = sync3_reg[i];
            end
        end
    end

    // Read data, driver control and crossbar skip
    always_comb
    begin
        rdata_next = rdata_reg;
        if (sfr_rd_i)
        begin
            rdata_next = 8'h00;
            if (ppcl_hit(sfr_addr_i, PPCL_ADDR_DRIVER_TYPE))
            begin
                rdata_next = driver_type_reg;
            end
            if (ppcl_hit(sfr_addr_i, PPCL_ADDR_LATCH))
            begin
                rdata_next = level_reg & analog_sel_reg; // [R5]
            end
            if (ppcl_hit(sfr_addr_i, PPCL_ADDR_SKIP))
            begin
                rdata_next = skip_reg;
            end
            if (ppcl_hit(sfr_addr_i, PPCL_ADDR_ANALOG_SEL))
            begin
                rdata_next = analog_sel_reg;
            end
        end
        for (int i = 0; i < 8; i++)
        begin
            pin_out_next[i] = latch_reg[i]; // [R3]
            if (!analog_sel_reg[i])
            begin
                pin_oe_next[i] = 1'b0; // [R6] [R8]
            end
            else if (!latch_reg[i])
            begin
                pin_oe_next[i] = 1'b1; // [R3]
            end
            else
            begin
                pin_oe_next[i] = driver_type_reg[i]; // [R4] [R7] [R8]
            end
        end
        pullup_next = analog_sel_reg; // [R8]
        rx_en_next = analog_sel_reg; // [R8]
        xbar_skip_next = skip_reg[PPCL_SKIP_LSB +: PPCL_SKIP_WIDTH]; // [R1]
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            driver_type_reg <= PPCL_RST_DRIVER_TYPE;
            latch_reg <= PPCL_RST_LATCH;
            skip_reg <= PPCL_RST_SKIP;
            analog_sel_reg <= PPCL_RST_ANALOG_SEL;
            sync1_reg <= PPCL_RST_PIN_SYNC;
            sync2_reg <= PPCL_RST_PIN_SYNC;
            sync3_reg <= PPCL_RST_PIN_SYNC;
            level_reg <= PPCL_RST_PIN_SYNC;
            rdata_reg <= PPCL_RST_RDATA;
            pin_out_reg <= PPCL_RST_LATCH;
            pin_oe_reg <= PPCL_RST_PIN_OE;
            pullup_reg <= PPCL_RST_ANALOG_SEL;
            rx_en_reg <= PPCL_RST_ANALOG_SEL;
            xbar_skip_reg <= PPCL_RST_XBAR_SKIP;
        end
        else
        begin
            driver_type_reg <= driver_type_next;
            latch_reg <= latch_next;
            skip_reg <= skip_next;
            analog_sel_reg <= analog_sel_next;
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sync3_reg <= sync3_next;
            level_reg <= level_next;
            rdata_reg <= rdata_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
            pullup_reg <= pullup_next;
            rx_en_reg <= rx_en_next;
            xbar_skip_reg <= xbar_skip_next;
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign port4_pin_o = pin_out_reg;
    assign port4_pin_oe_o = pin_oe_reg;
    assign port4_pullup_en_o = pullup_reg;
    assign port4_digital_rx_en_o = rx_en_reg;
    assign port3_crossbar_skip_o = xbar_skip_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_skip_follows_write;
        sfr_wr_i && ppcl_hit(sfr_addr_i, PPCL_ADDR_SKIP)
            |=> ##1 port3_crossbar_skip_o == $past(sfr_wdata_i[3:0], 2);
    endproperty
    a_skip_follows_write: assert property (p_skip_follows_write) // [R1]
        else $error("crossbar skip does not follow written value");

    property p_low_write_drives_low;
        sfr_wr_i && ppcl_hit(sfr_addr_i, PPCL_ADDR_LATCH) && !sfr_wdata_i[0] && analog_sel_reg[0]
            && !(sfr_wr_i && ppcl_hit(sfr_addr_i, PPCL_ADDR_ANALOG_SEL))
            |=> ##1 (port4_pin_oe_o[0] && !port4_pin_o[0]);
    endproperty
    a_low_write_drives_low: assert property (p_low_write_drives_low) // [R3]
        else $error("latch zero did not drive pin low");

    property p_latch_low_driven;
        analog_sel_reg[2] && !latch_reg[2] |=> port4_pin_oe_o[2] && !port4_pin_o[2];
    endproperty
    a_latch_low_driven: assert property (p_latch_low_driven) // [R3]
        else $error("latched zero pin not driven low");

    property p_open_drain_floats;
        latch_reg[2] && !driver_type_reg[2] |=> !port4_pin_oe_o[2];
    endproperty
    a_open_drain_floats: assert property (p_open_drain_floats) // [R4] [R7]
        else $error("open-drain pin driven high");

    property p_analog_reads_zero;
        sfr_rd_i && ppcl_hit(sfr_addr_i, PPCL_ADDR_LATCH) && !analog_sel_reg[7]
            |=> !sfr_rdata_o[7];
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero) // [R5]
        else $error("analog pin read not zero");

    property p_digital_reads_pin;
        $stable(port4_pin_i[4]) [*4]
            ##0 (sfr_rd_i && ppcl_hit(sfr_addr_i, PPCL_ADDR_LATCH) && analog_sel_reg[4])
            |=> sfr_rdata_o[4] == $past(port4_pin_i[4], 2);
    endproperty
    a_digital_reads_pin: assert property (p_digital_reads_pin) // [R5]
        else $error("digital pin read does not match pin");

    property p_analog_not_driven;
        !analog_sel_reg[5] |=> !port4_pin_oe_o[5] && !port4_pullup_en_o[5];
    endproperty
    a_analog_not_driven: assert property (p_analog_not_driven) // [R6] [R8]
        else $error("analog pin driven or pulled up");

    property p_push_pull_high;
        analog_sel_reg[6] && latch_reg[6] && driver_type_reg[6]
            |=> port4_pin_oe_o[6] && port4_pin_o[6];
    endproperty
    a_push_pull_high: assert property (p_push_pull_high) // [R8]
        else $error("push-pull pin not driven high");

endmodule : ppcl_port_pin_config_latch

// *** dv/ppcl_port_pin_config_latch_tb.sv ***
`timescale 1ns/1ps
module ppcl_port_pin_config_latch_tb;
    import ppcl_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [7:0] sfr_rdata_o;
    logic [7:0] port4_pin_i = 8'hFF;
    logic [7:0] port4_pin_o;
    logic [7:0] port4_pin_oe_o;
    logic [7:0] port4_pullup_en_o;
    logic [7:0] port4_digital_rx_en_o;
    logic [3:0] port3_crossbar_skip_o;
    int num_errors = 0;
    int check_count = 0;

    ppcl_port_pin_config_latch uut (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o),
        .port4_pin_i(port4_pin_i),
        .port4_pin_o(port4_pin_o),
        .port4_pin_oe_o(port4_pin_oe_o),
        .port4_pullup_en_o(port4_pullup_en_o),
        .port4_digital_rx_en_o(port4_digital_rx_en_o),
        .port3_crossbar_skip_o(port3_crossbar_skip_o)
    );

    initial
    begin
        forever #25 core_clk_i = ~core_clk_i;
    end

    // Inputs change 5 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #5;
    endtask : step

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        step(1);
        sfr_wr_i = 1'b0;
        step(2);
    endtask : sfr_write

    task automatic read_check(input logic [7:0] a, input logic [7:0] exp, input string msg);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        step(1);
        sfr_rd_i = 1'b0;
        check(sfr_rdata_o, exp, msg);
    endtask : read_check

    task automatic reset_values;
        check(port4_pin_o, PPCL_RST_LATCH, "pin out");
        check(port4_pin_oe_o, 8'h00, "oe");
        check(port4_pullup_en_o, 8'hFF, "pullup");
        check(port4_digital_rx_en_o, 8'hFF, "rx en");
        check({4'h0, port3_crossbar_skip_o}, 8'h00, "skip out");
        read_check(PPCL_ADDR_DRIVER_TYPE, 8'h00, "driver rst");
        read_check(PPCL_ADDR_SKIP, PPCL_RST_SKIP, "skip rst");
        read_check(PPCL_ADDR_ANALOG_SEL, 8'hFF, "select rst");
        read_check(PPCL_ADDR_LATCH, 8'hFF, "pin level rst");
    endtask : reset_values

    task automatic latch_drive;
        sfr_write(PPCL_ADDR_LATCH, 8'h5A);
        check(port4_pin_o, 8'h5A, "pin out");
        check(port4_pin_oe_o, 8'hA5, "open-drain oe");
        sfr_write(PPCL_ADDR_DRIVER_TYPE, 8'hFF);
        check(port4_pin_oe_o, 8'hFF, "push-pull oe");
        read_check(PPCL_ADDR_DRIVER_TYPE, 8'hFF, "driver rb");
    endtask : latch_drive

    task automatic analog_mode;
        sfr_write(PPCL_ADDR_ANALOG_SEL, 8'h0F);
        check(port4_pin_oe_o, 8'h0F, "analog oe");
        check(port4_pullup_en_o, 8'h0F, "analog pullup");
        check(port4_digital_rx_en_o, 8'h0F, "analog rx");
        port4_pin_i = 8'h33;
        step(6);
        read_check(PPCL_ADDR_LATCH, 8'h03, "pin level masked");
        read_check(PPCL_ADDR_ANALOG_SEL, 8'h0F, "select rb");
    endtask : analog_mode

    task automatic skip_bits;
        sfr_write(PPCL_ADDR_SKIP, 8'hA5);
        check({4'h0, port3_crossbar_skip_o}, 8'h05, "skip out");
        read_check(PPCL_ADDR_SKIP, 8'hA5, "skip rb");
        sfr_write(8'h12, 8'hFF);
        read_check(8'h12, 8'h00, "unmapped read");
        sfr_write(PPCL_ADDR_SKIP, 8'h0A);
        check({4'h0, port3_crossbar_skip_o}, 8'h0A, "skip flip");
    endtask : skip_bits

    // Reset in mid-run brings every register back to its idle value
    task automatic reset_midrun;
        port4_pin_i = 8'hFF;
        rst_i = 1'b1;
        step(2);
        rst_i = 1'b0;
        step(6);
        reset_values();
    endtask : reset_midrun

    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (5) @(posedge core_clk_i);
        #5;
        rst_i = 1'b0;
        step(6);
        reset_values();
        latch_drive();
        analog_mode();
        skip_bits();
        reset_midrun();
        print_verdict();
    end
endmodule : ppcl_port_pin_config_latch_tb
